// File: nps_params.svh
// constants of the negative-sequence step one reset and supervision block
`ifndef NPS_PARAMS_SVH
`define NPS_PARAMS_SVH

`define NPS_CLK_PERIOD_NS      10
`define NPS_CYCLE_TIME_US      1000
`define NPS_CYCLE_CLKS         ((`NPS_CYCLE_TIME_US * 1000) / `NPS_CLK_PERIOD_NS)

`define NPS_OFF_CTRL           8'h00
`define NPS_OFF_PICKUP_LIMIT   8'h04
`define NPS_OFF_RESET_LIMIT    8'h08
`define NPS_OFF_TRIP_DELAY     8'h0C
`define NPS_OFF_TRIP_RST_DLY   8'h10
`define NPS_OFF_PICK_RST_DLY   8'h14
`define NPS_OFF_MIN_START      8'h18
`define NPS_OFF_NOMINAL        8'h1C
`define NPS_OFF_STATUS         8'h20
`define NPS_OFF_TRIP_COUNT     8'h24

`define NPS_CTRL_RCURVE_LSB    0
`define NPS_CTRL_TCURVE_LSB    4
`define NPS_CTRL_IMMED_BIT     8
`define NPS_CTRL_REF_BIT       9
`define NPS_CTRL_VR_BIT        10
`define NPS_CTRL_HARM_LSB      11

`define NPS_RST_CTRL           16'h0000
`define NPS_RST_PICKUP_LIMIT   16'h0064
`define NPS_RST_RESET_LIMIT    16'h005F
`define NPS_RST_TRIP_DELAY     32'h0000_03E8
`define NPS_RST_TRIP_RST_DLY   32'h0000_0000
`define NPS_RST_PICK_RST_DLY   32'h0000_0000
`define NPS_RST_MIN_START      16'h0000
`define NPS_RST_NOMINAL        16'h0001

`define NPS_PCT_FULL           32'h0000_0064
`define NPS_THERM_RESET_K      32'h0000_002D

`endif

// File: nps_pkg.sv
// types of the negative-sequence step one reset and supervision block
package nps_pkg;

  typedef enum logic [3:0] {
    NPS_CURVE_DEFINITE = 4'h0,
    NPS_CURVE_ANSI_NI  = 4'h1,
    NPS_CURVE_ANSI_VI  = 4'h2,
    NPS_CURVE_ANSI_EI  = 4'h3,
    NPS_CURVE_IEC_NI   = 4'h4,
    NPS_CURVE_IEC_VI   = 4'h5,
    NPS_CURVE_IEC_LI   = 4'h6,
    NPS_CURVE_IEC_EI   = 4'h7,
    NPS_CURVE_THERM_FL = 4'h8,
    NPS_CURVE_THERM_IT = 4'h9,
    NPS_CURVE_THERM_I2 = 4'hA,
    NPS_CURVE_THERM_I4 = 4'hB
  } nps_curve_e;

  typedef enum logic [1:0] {
    NPS_HARM_OFF  = 2'h0,
    NPS_HARM_2H   = 2'h1,
    NPS_HARM_5H   = 2'h2,
    NPS_HARM_2H5H = 2'h3
  } nps_harm_e;

  typedef struct packed {
    logic [15:0] negative_sequence;
    logic [15:0] nps_ratio_pct;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
    logic        harm2_excess;
    logic        harm5_excess;
    logic [7:0]  vr_factor;
  } nps_meas_s;

  typedef struct packed {
    logic [3:0]  reset_curve_select;
    logic [3:0]  trip_curve_select;
    logic        immediate_trip_reset_enable;
    logic        reference_select;
    logic        voltage_restraint_enable;
    logic [1:0]  harmonic_block_select;
  } nps_ctrl_s;

endpackage : nps_pkg

// File: nps_step_one.sv
// reset characteristic, reset timers and supervision of negative-sequence step one
//
// Behaviour
// [R1] reset curve is definite time, seven inverse curves, or thermal
// [R2] definite-time trip curve allows only definite-time reset curve
// [R3] inverse or thermal trip curve allows definite or inverse/thermal reset
// [R4] four thermal reset shapes: flat, IT, I2T, I4T; all four share NPS_THERM_RESET_K and reset alike
// [R5] definite reset: stored trip counter follows the pickup-reset delay
// [R6] inverse/thermal reset: stored trip counter follows the trip-reset delay
// [R7] inverse reset with immediate option clears trip below reset limit
// [R8] definite reset with zero trip-reset delay clears trip immediately
// [R9] pickup drops below both limits: clear pickup, start pickup-reset timer
// [R10] ratio reference compares percentage directly, else percent of nominal current
// [R11] definite reset uses constant trip-reset delay setting
// [R12] inverse reset recalculates trip-reset delay each cycle, setting scales time
// [R13] trip clears once trip-reset delay fully elapsed
// [R14] pickup-reset delay applies only with definite reset curve
// [R15] trip counter frozen while pickup-reset timer runs
// [R16] pickup-reset expiry before trip clears stored trip counter
// [R17] harmonic blocking of pickup: off, 2nd, 5th or either
// [R18] voltage restraint scales pickup and reset limits when enabled
// [R19] all phases below minimum start current block step, flag asserted
// [R20] pickup and trip timer start when quantity exceeds pickup limit
// [R21] below pickup limit before trip: timer stops, keeps value
// [R22] pickup with elapsed trip delay asserts trip
// [R23] everything evaluated once per protection cycle, delays in cycles
`timescale 1ns/1ps
`include "nps_params.svh"

module nps_step_one
  import nps_pkg::*;
#(
  parameter int unsigned CYCLE_CLKS = `NPS_CYCLE_CLKS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire nps_meas_s   meas,
  output logic             pickup_flag,
  output logic             trip_flag,
  output logic             step_blocked_flag
);

  function automatic logic is_definite(input logic [3:0] c);
    return c == NPS_CURVE_DEFINITE;
  endfunction : is_definite

  function automatic logic is_legal_curve(input logic [3:0] c);
    return c <= NPS_CURVE_THERM_I4;
  endfunction : is_legal_curve

  // quantity above a limit, limit in percent of nominal or direct percent
  function automatic logic exceeds(input logic [15:0] q, input logic [15:0] lim,
                                   input logic [15:0] nom, input logic ratio);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = {16'h0000, q};
    rhs = {16'h0000, lim};
    if (!ratio) begin
      lhs = lhs * `NPS_PCT_FULL;
      rhs = rhs * {16'h0000, nom};
    end
    return lhs > rhs;
  endfunction : exceeds

  function automatic logic below(input logic [15:0] q, input logic [15:0] lim,
                                 input logic [15:0] nom, input logic ratio);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = {16'h0000, q};
    rhs = {16'h0000, lim};
    if (!ratio) begin
      lhs = lhs * `NPS_PCT_FULL;
      rhs = rhs * {16'h0000, nom};
    end
    return lhs < rhs;
  endfunction : below

  // voltage restraint sensitises a limit by factor/256
  function automatic logic [15:0] vr_scale(input logic [15:0] lim, input logic en,
                                           input logic [7:0] f);
    logic [23:0] p;
    p = {8'h00, lim} * {16'h0000, f};
    return en ? p[23:8] : lim;
  endfunction : vr_scale

  // per-curve reset time constant, multiplied by the setting
  function automatic logic [31:0] curve_k(input logic [3:0] c);
    logic [31:0] k;
    k = 32'h0000_0001;
    unique case (c)
      NPS_CURVE_ANSI_NI:  k = 32'h0000_0005;
      NPS_CURVE_ANSI_VI:  k = 32'h0000_0004;
      NPS_CURVE_ANSI_EI:  k = 32'h0000_0006;
      NPS_CURVE_IEC_NI:   k = 32'h0000_0002;
      NPS_CURVE_IEC_VI:   k = 32'h0000_0003;
      NPS_CURVE_IEC_LI:   k = 32'h0000_0008;
      NPS_CURVE_IEC_EI:   k = 32'h0000_0007;
      NPS_CURVE_THERM_FL, NPS_CURVE_THERM_IT,
      NPS_CURVE_THERM_I2, NPS_CURVE_THERM_I4: k = `NPS_THERM_RESET_K; // [R4]
      default:            k = 32'h0000_0001;
    endcase
    return k;
  endfunction : curve_k

  nps_ctrl_s   ctrl;
  logic [15:0] pickup_limit;
  logic [15:0] reset_limit;
  logic [31:0] trip_delay_multiplier;
  logic [31:0] trip_reset_delay;
  logic [31:0] pickup_reset_delay;
  logic [15:0] min_start_current;
  logic [15:0] nominal_current;

  // AHB-Lite slave
  logic       dp_write;
  logic [7:0] dp_addr;
  logic       ap_valid;
  logic [3:0] wr_rcurve;
  logic [3:0] wr_tcurve;

  assign ap_valid = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= ap_valid && hwrite && (haddr[31:8] == 24'h000000);
      dp_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign wr_tcurve = is_legal_curve(hwdata[`NPS_CTRL_TCURVE_LSB +: 4]) ?
                     hwdata[`NPS_CTRL_TCURVE_LSB +: 4] : NPS_CURVE_DEFINITE;
  assign wr_rcurve = (is_definite(wr_tcurve) ||                                  // [R2]
                      !is_legal_curve(hwdata[`NPS_CTRL_RCURVE_LSB +: 4])) ?
                     NPS_CURVE_DEFINITE : hwdata[`NPS_CTRL_RCURVE_LSB +: 4];      // [R1] [R3]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl                  <= nps_ctrl_s'(`NPS_RST_CTRL);
      pickup_limit          <= `NPS_RST_PICKUP_LIMIT;
      reset_limit           <= `NPS_RST_RESET_LIMIT;
      trip_delay_multiplier <= `NPS_RST_TRIP_DELAY;
      trip_reset_delay      <= `NPS_RST_TRIP_RST_DLY;
      pickup_reset_delay    <= `NPS_RST_PICK_RST_DLY;
      min_start_current     <= `NPS_RST_MIN_START;
      nominal_current       <= `NPS_RST_NOMINAL;
    end else if (dp_write) begin
      unique case (dp_addr)
        `NPS_OFF_CTRL: begin
          ctrl.reset_curve_select          <= wr_rcurve;
          ctrl.trip_curve_select           <= wr_tcurve;
          ctrl.immediate_trip_reset_enable <= hwdata[`NPS_CTRL_IMMED_BIT];
          ctrl.reference_select            <= hwdata[`NPS_CTRL_REF_BIT];
          ctrl.voltage_restraint_enable    <= hwdata[`NPS_CTRL_VR_BIT];
          ctrl.harmonic_block_select       <= hwdata[`NPS_CTRL_HARM_LSB +: 2];
        end
        `NPS_OFF_PICKUP_LIMIT: pickup_limit          <= hwdata[15:0];
        `NPS_OFF_RESET_LIMIT:  reset_limit           <= hwdata[15:0];
        `NPS_OFF_TRIP_DELAY:   trip_delay_multiplier <= hwdata;
        `NPS_OFF_TRIP_RST_DLY: trip_reset_delay      <= hwdata;
        `NPS_OFF_PICK_RST_DLY: pickup_reset_delay    <= hwdata;
        `NPS_OFF_MIN_START:    min_start_current     <= hwdata[15:0];
        `NPS_OFF_NOMINAL:      nominal_current       <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  logic [31:0] trip_count;
  logic [31:0] pr_timer;
  logic        pr_running;
  logic [31:0] tr_timer;
  logic [31:0] ir_timer;
  logic [31:0] cyc_cnt;
  logic        tick;

  logic [31:0] ctrl_rd;
  assign ctrl_rd = {19'h00000, ctrl.harmonic_block_select, ctrl.voltage_restraint_enable,
                    ctrl.reference_select, ctrl.immediate_trip_reset_enable,
                    ctrl.trip_curve_select, ctrl.reset_curve_select};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite && (haddr[31:8] == 24'h000000)) begin
      unique case (haddr[7:0])
        `NPS_OFF_CTRL:         hrdata <= ctrl_rd;
        `NPS_OFF_PICKUP_LIMIT: hrdata <= {16'h0000, pickup_limit};
        `NPS_OFF_RESET_LIMIT:  hrdata <= {16'h0000, reset_limit};
        `NPS_OFF_TRIP_DELAY:   hrdata <= trip_delay_multiplier;
        `NPS_OFF_TRIP_RST_DLY: hrdata <= trip_reset_delay;
        `NPS_OFF_PICK_RST_DLY: hrdata <= pickup_reset_delay;
        `NPS_OFF_MIN_START:    hrdata <= {16'h0000, min_start_current};
        `NPS_OFF_NOMINAL:      hrdata <= {16'h0000, nominal_current};
        `NPS_OFF_STATUS:       hrdata <= {28'h0000000, pr_running, step_blocked_flag,
                                          trip_flag, pickup_flag};
        `NPS_OFF_TRIP_COUNT:   hrdata <= trip_count;
        default:               hrdata <= 32'h0000_0000;
      endcase
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // protection cycle strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else begin
      tick    <= (cyc_cnt == CYCLE_CLKS - 1);                                       // [R23]
      cyc_cnt <= (cyc_cnt == CYCLE_CLKS - 1) ? 32'h0000_0000 : cyc_cnt + 32'h0000_0001;
    end
  end

  logic [15:0] q;
  logic [15:0] eff_pick;
  logic [15:0] eff_reset;
  logic        over_pick;
  logic        under_pick;
  logic        under_reset;
  logic        harm_block;
  logic        min_block;
  logic        rdef;
  logic [31:0] tr_target;
  logic [31:0] tr_base;

  assign q = ctrl.reference_select ? meas.nps_ratio_pct : meas.negative_sequence; // [R10]
  assign eff_pick  = vr_scale(pickup_limit, ctrl.voltage_restraint_enable,
                              meas.vr_factor);                                    // [R18]
  assign eff_reset = vr_scale(reset_limit, ctrl.voltage_restraint_enable,
                              meas.vr_factor);                                    // [R18]
  assign over_pick   = exceeds(q, eff_pick, nominal_current, ctrl.reference_select);
  assign under_pick  = below(q, eff_pick, nominal_current, ctrl.reference_select);
  assign under_reset = below(q, eff_reset, nominal_current, ctrl.reference_select);
  assign min_block   = below(meas.phase_a, min_start_current, nominal_current, 1'b0) &&
                       below(meas.phase_b, min_start_current, nominal_current, 1'b0) &&
                       below(meas.phase_c, min_start_current, nominal_current, 1'b0); // [R19]

  always_comb begin
    unique case (ctrl.harmonic_block_select)                                      // [R17]
      NPS_HARM_OFF:  harm_block = 1'b0;
      NPS_HARM_2H:   harm_block = meas.harm2_excess;
      NPS_HARM_5H:   harm_block = meas.harm5_excess;
      NPS_HARM_2H5H: harm_block = meas.harm2_excess || meas.harm5_excess;
    endcase
  end

  // reset delay: constant for definite, recalculated from quantity otherwise
  assign rdef    = is_definite(ctrl.reset_curve_select);
  assign tr_base = trip_reset_delay * curve_k(ctrl.reset_curve_select);           // [R12]
  always_comb begin
    if (rdef) begin
      tr_target = trip_reset_delay;                                               // [R11]
    end else if ({q, 2'b00} < {2'b00, eff_reset}) begin
      tr_target = tr_base;                                                        // [R12]
    end else if ({q, 1'b0} < {1'b0, eff_reset}) begin
      tr_target = {tr_base[30:0], 1'b0};
    end else begin
      tr_target = {tr_base[29:0], 2'b00};
    end
  end

  // pickup, trip counter and pickup-reset timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pickup_flag <= 1'b0;
      trip_count  <= 32'h0000_0000;
      pr_running  <= 1'b0;
      pr_timer    <= 32'h0000_0000;
    end else if (tick) begin
      if (min_block || harm_block) begin
        pickup_flag <= 1'b0;                                                      // [R17] [R19]
        pr_running  <= 1'b0;
      end else if (over_pick) begin
        pickup_flag <= 1'b1;                                                      // [R20]
        pr_running  <= 1'b0;
        pr_timer    <= 32'h0000_0000;
        if (trip_count < trip_delay_multiplier) begin
          trip_count <= trip_count + 32'h0000_0001;                               // [R20]
        end
      end else if (pickup_flag && under_pick && under_reset) begin
        pickup_flag <= 1'b0;                                                      // [R9]
        pr_running  <= rdef;                                                      // [R14]
        pr_timer    <= 32'h0000_0000;
      end else if (!rdef && under_reset && !trip_flag &&
                   ir_timer + 32'h0000_0001 >= tr_target) begin
        trip_count <= 32'h0000_0000;                                              // [R6]
      end else if (pr_running) begin
        if (pr_timer + 32'h0000_0001 >= pickup_reset_delay) begin                 // [R5]
          pr_running <= 1'b0;
          if (!trip_flag) begin
            trip_count <= 32'h0000_0000;                                          // [R16]
          end
        end else begin
          pr_timer <= pr_timer + 32'h0000_0001;                                   // [R15]
        end
      end
    end
  end

  // trip flag and trip-reset timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_flag <= 1'b0;
      tr_timer  <= 32'h0000_0000;
    end else if (tick) begin
      if (pickup_flag && over_pick && trip_count >= trip_delay_multiplier) begin
        trip_flag <= 1'b1;                                                        // [R22]
        tr_timer  <= 32'h0000_0000;
      end else if (!under_reset) begin
        tr_timer <= 32'h0000_0000;
      end else if (!rdef && ctrl.immediate_trip_reset_enable) begin
        trip_flag <= 1'b0;                                                        // [R7]
        tr_timer  <= 32'h0000_0000;
      end else if (tr_timer + 32'h0000_0001 >= tr_target) begin
        trip_flag <= 1'b0;                                                        // [R8] [R13]
        tr_timer  <= 32'h0000_0000;
      end else begin
        tr_timer <= tr_timer + 32'h0000_0001;
      end
    end
  end

  // inverse reset: stored trip counter cleared when the trip-reset delay runs out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_timer <= 32'h0000_0000;
    end else if (tick) begin
      if (rdef || !under_reset || pickup_flag) begin
        ir_timer <= 32'h0000_0000;
      end else if (ir_timer + 32'h0000_0001 < tr_target) begin
        ir_timer <= ir_timer + 32'h0000_0001;                                     // [R6]
      end
    end
  end

  // step blocked flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_blocked_flag <= 1'b0;
    end else if (tick) begin
      step_blocked_flag <= min_block;                                             // [R19]
    end
  end

endmodule : nps_step_one

// File: nps_step_one_asserts.sv
// port-level checker of negative-sequence step one
`timescale 1ns/1ps

module nps_step_one_asserts
  import nps_pkg::*;
#(
  parameter int unsigned CYCLE_CLKS = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire nps_meas_s   meas,
  input wire logic        pickup_flag,
  input wire logic        trip_flag,
  input wire logic        step_blocked_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic              rd_req;
  logic              chg;
  logic [2:0]        flags_q;
  int unsigned       since_chg;

  assign rd_req = hsel && htrans[1] && hready && !hwrite;
  assign chg    = {pickup_flag, trip_flag, step_blocked_flag} != flags_q;

  // cycles since any flag last moved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q   <= 3'h0;
      since_chg <= 0;
    end else begin
      flags_q   <= {pickup_flag, trip_flag, step_blocked_flag};
      since_chg <= chg ? 0 : since_chg + 1;
    end
  end

  sequence s_rise_trip;
    $rose(trip_flag);
  endsequence
  sequence s_rise_pickup;
    $rose(pickup_flag);
  endsequence

  property p_okay;
    hresetn |=> (hreadyout && !hresp);
  endproperty
  property p_rd_idle;
    !rd_req |=> hrdata == 32'h0;
  endproperty
  property p_trip_pickup;
    s_rise_trip |-> pickup_flag;
  endproperty
  property p_trip_cause;
    s_rise_trip |-> ($past(meas.negative_sequence) != 16'h0 || $past(meas.nps_ratio_pct) != 16'h0);
  endproperty
  property p_pickup_cause;
    s_rise_pickup |-> ($past(meas.negative_sequence) != 16'h0 || $past(meas.nps_ratio_pct) != 16'h0);
  endproperty
  property p_block_pickup;
    step_blocked_flag |-> !pickup_flag;
  endproperty
  property p_tick_gap;
    chg |-> since_chg >= CYCLE_CLKS - 1;
  endproperty
  property p_trip_clear;
    $fell(trip_flag) |-> !pickup_flag;
  endproperty

  a_okay:         assert property (p_okay) else $error("bus not ready or not okay");
  a_rd_idle:      assert property (p_rd_idle) else $error("read data outside data phase");
  a_trip_pickup:  assert property (p_trip_pickup) else $error("trip without pickup");
  a_trip_cause:   assert property (p_trip_cause) else $error("trip with no quantity");
  a_pickup_cause: assert property (p_pickup_cause) else $error("pickup with no quantity");
  a_block_pickup: assert property (p_block_pickup) else $error("pickup while blocked");
  a_tick_gap:     assert property (p_tick_gap) else $error("flags moved between ticks");
  a_trip_clear:   assert property (p_trip_clear) else $error("trip cleared above limit");
endmodule : nps_step_one_asserts

bind nps_step_one nps_step_one_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .meas(meas), .pickup_flag(pickup_flag),
  .trip_flag(trip_flag), .step_blocked_flag(step_blocked_flag));

// File: nps_step_one_tb_top.sv
// self-checking bench of negative-sequence step one
`timescale 1ns/1ps
`include "nps_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("BAD %0t %h %h", $time, g, e); end end

module nps_step_one_tb_top
  import nps_pkg::*;
;
  localparam int CYC = 8;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  nps_meas_s   meas = '0;
  logic        pickup_flag;
  logic        trip_flag;
  logic        step_blocked_flag;
  logic [31:0] r;
  int          err_total = 0;
  int          checks = 0;
  int          seed = 47;

  always #5 hclk = ~hclk;

  nps_step_one #(.CYCLE_CLKS(CYC)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas(meas), .pickup_flag(pickup_flag),
    .trip_flag(trip_flag), .step_blocked_flag(step_blocked_flag));

  task print_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask : rd_chk

  task automatic set_m(input logic [15:0] q, input logic [15:0] p, input logic [1:0] h,
                       input logic [7:0] vr);
    @(posedge hclk);
    meas.negative_sequence <= q;
    meas.nps_ratio_pct     <= p;
    meas.harm2_excess      <= h[1];
    meas.harm5_excess      <= h[0];
    meas.vr_factor         <= vr;
  endtask : set_m

  task automatic clks(input int n);
    repeat (n) @(posedge hclk);
  endtask : clks

  task automatic wait_pk(input logic v);
    while (pickup_flag !== v) @(posedge hclk);
  endtask : wait_pk

  task automatic go_trip;
    set_m(16'h00C8, 16'h0, 2'h0, 8'h0);
    wait_pk(1'b1);
    clks(3 * CYC + CYC / 2);
    `CHK(trip_flag, 1'b1)
  endtask : go_trip

  task automatic drop;
    set_m(16'h0, 16'h0, 2'h0, 8'h0);
    wait_pk(1'b0);
    clks(CYC / 2);
  endtask : drop

  task automatic cnt_run(input int hold);
    set_m(16'h00C8, 16'h0, 2'h0, 8'h0);
    wait_pk(1'b1);
    clks(2 * CYC + CYC / 2);
    set_m(16'h0, 16'h0, 2'h0, 8'h0);
    wait_pk(1'b0);
    clks(hold);
  endtask : cnt_run

  function automatic logic [31:0] exp_ctrl(input logic [3:0] t, input logic [3:0] c);
    return {24'h0, t, (t == 4'h0 || c > 4'hB) ? 4'h0 : c};
  endfunction : exp_ctrl

  function automatic logic exp_pk(input logic [1:0] s, input logic [1:0] h);
    return !((s[0] & h[1]) | (s[1] & h[0]));
  endfunction : exp_pk

  function automatic logic exp_lim(input logic [15:0] c, input logic [15:0] q,
                                   input logic [15:0] p);
    return c[9] ? (p > 16'h0064) : (q > (c[10] ? 16'h0032 : 16'h0064));
  endfunction : exp_lim

  initial begin
    logic [31:0] rv [8] = '{32'h0, 32'h64, 32'h5F, 32'h3E8, 32'h0, 32'h0, 32'h0, 32'h1};
    logic [47:0] lt [4] = '{{16'h200, 16'h0, 16'h96}, {16'h200, 16'h0, 16'h0},
                            {16'h400, 16'h46, 16'h0}, {16'h0, 16'h46, 16'h0}};
    logic [15:0] q;
    meas.phase_a = 16'h03E8;
    meas.phase_b = 16'h03E8;
    meas.phase_c = 16'h03E8;
    clks(6);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(32'(i * 4), rv[i]);
    wr(32'h100, 32'hFFFF_FFFF);
    rd_chk(32'h100, 32'h0);
    $display("register test done");
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 13; c++) begin
        wr(`NPS_OFF_CTRL, 32'(t * 16 + c));
        rd_chk(`NPS_OFF_CTRL, exp_ctrl(4'(t), 4'(c)));
      end
    end
    $display("curve test done");
    wr(`NPS_OFF_NOMINAL, 32'h64);
    wr(`NPS_OFF_TRIP_DELAY, 32'h3);
    wr(`NPS_OFF_TRIP_RST_DLY, 32'h3);
    wr(`NPS_OFF_PICK_RST_DLY, 32'h2);
    wr(`NPS_OFF_CTRL, 32'h0);
    set_m(16'h00C8, 16'h0, 2'h0, 8'h0);
    wait_pk(1'b1);
    clks(2 * CYC + CYC / 2);
    `CHK(trip_flag, 1'b0)
    clks(CYC);
    `CHK(trip_flag, 1'b1)
    drop();
    `CHK(trip_flag, 1'b1)
    clks(CYC);
    `CHK(trip_flag, 1'b1)
    clks(CYC);
    `CHK(trip_flag, 1'b0)
    wr(`NPS_OFF_TRIP_RST_DLY, 32'h0);
    go_trip();
    drop();
    `CHK(trip_flag, 1'b0)
    wr(`NPS_OFF_TRIP_RST_DLY, 32'h32);
    wr(`NPS_OFF_CTRL, 32'h111);
    go_trip();
    drop();
    `CHK(trip_flag, 1'b0)
    wr(`NPS_OFF_CTRL, 32'h11);
    go_trip();
    drop();
    clks(3 * CYC);
    `CHK(trip_flag, 1'b1)
    wr(`NPS_OFF_CTRL, 32'h111);
    clks(2 * CYC);
    `CHK(trip_flag, 1'b0)
    $display("trip reset test done");
    wr(`NPS_OFF_TRIP_DELAY, 32'h14);
    wr(`NPS_OFF_PICK_RST_DLY, 32'h4);
    wr(`NPS_OFF_CTRL, 32'h0);
    cnt_run(6 * CYC);
    rd_chk(`NPS_OFF_TRIP_COUNT, 32'h0);
    cnt_run(CYC);
    rd_chk(`NPS_OFF_TRIP_COUNT, 32'h3);
    clks(4 * CYC);
    rd_chk(`NPS_OFF_TRIP_COUNT, 32'h0);
    wr(`NPS_OFF_CTRL, 32'h11);
    cnt_run(6 * CYC);
    rd_chk(`NPS_OFF_TRIP_COUNT, 32'h3);
    clks(250 * CYC);
    rd_chk(`NPS_OFF_TRIP_COUNT, 32'h0);
    $display("counter test done");
    for (int s = 0; s < 4; s++) begin
      wr(`NPS_OFF_CTRL, 32'(s) << 11);
      for (int h = 0; h < 4; h++) begin
        set_m(16'h00C8, 16'h0, 2'(h), 8'h0);
        clks(2 * CYC);
        `CHK(pickup_flag, exp_pk(2'(s), 2'(h)))
        set_m(16'h0, 16'h0, 2'h0, 8'h0);
        clks(2 * CYC);
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(`NPS_OFF_CTRL, {16'h0, lt[i][47:32]});
      set_m(lt[i][31:16], lt[i][15:0], 2'h0, lt[i][42] ? 8'h80 : 8'h0);
      clks(2 * CYC);
      `CHK(pickup_flag, exp_lim(lt[i][47:32], lt[i][31:16], lt[i][15:0]))
    end
    $display("pickup test done");
    wr(`NPS_OFF_MIN_START, 32'h32);
    wr(`NPS_OFF_CTRL, 32'h0);
    @(posedge hclk);
    meas.phase_a <= 16'h000A;
    meas.phase_b <= 16'h000A;
    meas.phase_c <= 16'h000A;
    set_m(16'h00C8, 16'h0, 2'h0, 8'h0);
    clks(2 * CYC);
    `CHK(step_blocked_flag, 1'b1)
    `CHK(pickup_flag, 1'b0)
    @(posedge hclk);
    meas.phase_b <= 16'h03E8;
    clks(2 * CYC);
    `CHK(step_blocked_flag, 1'b0)
    for (int i = 0; i < 8; i++) begin
      q = 16'($random(seed)) & 16'h00FF;
      set_m(16'h0, 16'h0, 2'h0, 8'h0);
      clks(2 * CYC);
      set_m(q, 16'h0, 2'h0, 8'h0);
      clks(2 * CYC);
      `CHK(pickup_flag, q > 16'h0064)
    end
    $display("block and random test done");
    print_verdict();
  end

  initial begin
    clks(30000);
    err_total++;
    print_verdict();
  end
endmodule : nps_step_one_tb_top
